// ### rtl/dps_top.sv
// dual-port synchronous memory, 64K x 18, burst counter per port
// assumes port pins synchronous to REF_CLK, each port clock a sampled input
// Behaviour
// - two independent ports access any location together, even the same one.
// - array is 64K words of 18 bits, 16 address bits per port.
// - each port captures control, address, data on its own clock rising edge.
// - port clock may run free or gated; only edges matter.
// - strobe sampled low loads burst counter from the address inputs.
// - port selected only when low-active and high-active chip selects both asserted.
// - increment input sampled low steps the counter and accesses next word.
// - increment ignored when strobe or counter clear is sampled low.
// - counter clear sampled low sets counter to zero.
// - counter clear wins over strobe and increment.
// - counter spans whole array and wraps from last address to zero.
// - low lane select enables reads and writes on bits 0 to 8.
// - up lane select does the same for bits 9 to 17.
// - a read lane drives only with its select and output enable both low.
// - data pins drive during reads only while output enable is low.
// - read/write low writes the array; high reads it.
// - mode pin low gives flow-through output, high pipelined output.
// - pipelined data appears one port clock later; flow-through in capture cycle.
// - write is a self-timed pulse completing within one cycle.
// - one deselected sampled cycle powers the port down.
// - pipelined outputs need one selected cycle before reactivating after deselect.
`include "dps_defs.svh"

module dps_top (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // left port pins
   input wire dps_pkg::dps_port_in_s LEFT_IN,
   output dps_pkg::dps_port_out_s LEFT_OUT,
   // right port pins
   input wire dps_pkg::dps_port_in_s RIGHT_IN,
   output dps_pkg::dps_port_out_s RIGHT_OUT
);
   import dps_pkg::*;

   // storage for the whole array
   dps_data_t mem [`DPS_DEPTH];

   dps_port_in_s pin [`DPS_PORTS];
   dps_port_out_s pout [`DPS_PORTS];

   // per-port state
   logic clk_d_reg [`DPS_PORTS];
   dps_port_in_s cap_reg [`DPS_PORTS];
   dps_addr_t cnt_reg [`DPS_PORTS];
   dps_addr_t cnt_next [`DPS_PORTS];
   logic acc_reg [`DPS_PORTS];
   logic acc2_reg [`DPS_PORTS];
   dps_data_t rd_q_reg [`DPS_PORTS];
   dps_lane_t lane_a_reg [`DPS_PORTS];
   dps_data_t pipe_dat_reg [`DPS_PORTS];
   dps_lane_t pipe_lane_reg [`DPS_PORTS];
   dps_data_t shown_dat_reg [`DPS_PORTS];
   dps_lane_t shown_lane_reg [`DPS_PORTS];
   dps_data_t oe_reg [`DPS_PORTS];
   logic pd_reg [`DPS_PORTS];

   // decoded per-port controls
   logic port_edge [`DPS_PORTS];
   logic sel_cap [`DPS_PORTS];
   logic wr_go [`DPS_PORTS];
   logic rd_go [`DPS_PORTS];
   dps_lane_t lane_cap [`DPS_PORTS];
   dps_mode_e mode_cap [`DPS_PORTS];
   dps_data_t lane_mask [`DPS_PORTS];
   // other port writes the same word in this cycle
   logic wr_clash [`DPS_PORTS];

   assign pin[0] = LEFT_IN;
   assign pin[1] = RIGHT_IN;
   assign LEFT_OUT = pout[0];
   assign RIGHT_OUT = pout[1];

   // array access; right port written last, so it wins a same-address collision
   always_ff @(posedge REF_CLK) begin
      for (int p = 0; p < `DPS_PORTS; p++) begin
         if (wr_go[p] && lane_cap[p][0]) begin
            mem[cnt_reg[p]][`DPS_LO_LSB +: `DPS_LANE_W] <=
               cap_reg[p].wdata[`DPS_LO_LSB +: `DPS_LANE_W];
         end
         if (wr_go[p] && lane_cap[p][1]) begin
            mem[cnt_reg[p]][`DPS_HI_LSB +: `DPS_LANE_W] <=
               cap_reg[p].wdata[`DPS_HI_LSB +: `DPS_LANE_W];
         end
         rd_q_reg[p] <= mem[cnt_reg[p]];
      end
   end

   generate
      for (genvar p = 0; p < `DPS_PORTS; p++) begin : g_port

         // rising edge of the port's own clock
         assign port_edge[p] = pin[p].port_clk & ~clk_d_reg[p];

         // burst counter next value; clear first, then load, then step
         assign cnt_next[p] =
            !pin[p].burst_clear_n ? `DPS_CNT_RST :
            !pin[p].addr_strobe_n ? pin[p].addr :
            !pin[p].burst_incr_n ? dps_addr_t'(cnt_reg[p] + 1'b1) :
            cnt_reg[p];

         assign sel_cap[p] = ~cap_reg[p].chip_sel_low_n & cap_reg[p].chip_sel_high;
         assign wr_go[p] = acc_reg[p] & sel_cap[p] & ~cap_reg[p].rd_wr_n;
         assign rd_go[p] = acc_reg[p] & sel_cap[p] & cap_reg[p].rd_wr_n;
         assign lane_cap[p] = {~cap_reg[p].up_lane_sel_n, ~cap_reg[p].low_lane_sel_n};
         assign mode_cap[p] = (cap_reg[p].flow_or_piped_sel == `DPS_PIPED_LVL) ?
            DPS_PIPED : DPS_FLOW;
         assign lane_mask[p] = {{`DPS_LANE_W{shown_lane_reg[p][1]}},
            {`DPS_LANE_W{shown_lane_reg[p][0]}}};
         assign wr_clash[p] = wr_go[1-p] && cnt_reg[1-p] == cnt_reg[p];

         assign pout[p] = '{rdata: shown_dat_reg[p], rdata_oe: oe_reg[p], powered_down: pd_reg[p]};

         // input capture and counter, once per port clock edge
         always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
               clk_d_reg[p] <= 1'b0;
               cap_reg[p] <= '0;
               cnt_reg[p] <= `DPS_CNT_RST;
               acc_reg[p] <= 1'b0;
               acc2_reg[p] <= 1'b0;
               pd_reg[p] <= 1'b1;
            end else begin
               clk_d_reg[p] <= pin[p].port_clk;
               acc_reg[p] <= port_edge[p];
               acc2_reg[p] <= acc_reg[p];
               if (port_edge[p]) begin
                  cap_reg[p] <= pin[p];
                  cnt_reg[p] <= cnt_next[p];
                  pd_reg[p] <= pin[p].chip_sel_low_n | ~pin[p].chip_sel_high;
               end
            end
         end

         // read lanes for this access; writes and deselects drive nothing
         always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
               lane_a_reg[p] <= `DPS_LANE_OFF;
            end else if (acc_reg[p]) begin
               lane_a_reg[p] <= rd_go[p] ? lane_cap[p] : `DPS_LANE_OFF;
            end
         end

         // output register stage for pipelined mode
         always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
               pipe_dat_reg[p] <= `DPS_DATA_RST;
               pipe_lane_reg[p] <= `DPS_LANE_OFF;
            end else if (acc2_reg[p]) begin
               pipe_dat_reg[p] <= rd_q_reg[p];
               pipe_lane_reg[p] <= lane_a_reg[p];
            end
         end

         // shown data: flow bypasses the stage, piped waits one port edge
         always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
               shown_dat_reg[p] <= `DPS_DATA_RST;
               shown_lane_reg[p] <= `DPS_LANE_OFF;
            end else if (mode_cap[p] == DPS_FLOW && acc2_reg[p]) begin
               shown_dat_reg[p] <= rd_q_reg[p];
               shown_lane_reg[p] <= lane_a_reg[p];
            end else if (mode_cap[p] == DPS_PIPED && port_edge[p]) begin
               shown_dat_reg[p] <= pipe_dat_reg[p];
               shown_lane_reg[p] <= pipe_lane_reg[p];
            end
         end

         // pin enables follow output enable every cycle
         always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
               oe_reg[p] <= `DPS_DATA_RST;
            end else begin
               oe_reg[p] <= pin[p].out_en_n ? `DPS_DATA_RST : lane_mask[p];
            end
         end

         // checks
         a_cnt_load: assert property (@(posedge REF_CLK) disable iff (RST)
            port_edge[p] && pin[p].burst_clear_n && !pin[p].addr_strobe_n
            |=> cnt_reg[p] == $past(pin[p].addr))
            else $error("counter not loaded from strobe address");

         a_incr_ignored: assert property (@(posedge REF_CLK) disable iff (RST)
            port_edge[p] && pin[p].burst_clear_n && !pin[p].addr_strobe_n
            && !pin[p].burst_incr_n ##1 1 |-> cnt_reg[p] == $past(pin[p].addr, 1))
            else $error("increment acted during strobe");

         a_cnt_step: assert property (@(posedge REF_CLK) disable iff (RST)
            port_edge[p] && pin[p].burst_clear_n && pin[p].addr_strobe_n
            && !pin[p].burst_incr_n
            |=> cnt_reg[p] == dps_addr_t'($past(cnt_reg[p]) + 1'b1))
            else $error("burst counter did not step with wrap");

         a_cnt_clear: assert property (@(posedge REF_CLK) disable iff (RST)
            port_edge[p] && !pin[p].burst_clear_n |=> cnt_reg[p] == `DPS_CNT_RST)
            else $error("counter clear missed");

         a_clear_wins: assert property (@(posedge REF_CLK) disable iff (RST)
            port_edge[p] && !pin[p].burst_clear_n
            && (!pin[p].addr_strobe_n || !pin[p].burst_incr_n)
            |=> cnt_reg[p] == `DPS_CNT_RST)
            else $error("clear lost to strobe or increment");

         a_oe_gate: assert property (@(posedge REF_CLK) disable iff (RST)
            oe_reg[p] != `DPS_DATA_RST |-> $past(!pin[p].out_en_n))
            else $error("pins driven without output enable");

         a_flow_data: assert property (@(posedge REF_CLK) disable iff (RST)
            acc2_reg[p] && mode_cap[p] == DPS_FLOW
            |=> shown_dat_reg[p] == $past(rd_q_reg[p]))
            else $error("flow data not shown in capture cycle");

         a_write_pulse: assert property (@(posedge REF_CLK) disable iff (RST)
            wr_go[p] |-> $past(port_edge[p]) ##1 !wr_go[p])
            else $error("write pulse not single cycle");

         a_desel_down: assert property (@(posedge REF_CLK) disable iff (RST)
            port_edge[p] && (pin[p].chip_sel_low_n || !pin[p].chip_sel_high)
            |=> pd_reg[p])
            else $error("deselect did not power down");

         a_pd_wake: assert property (@(posedge REF_CLK) disable iff (RST)
            port_edge[p] && !pin[p].chip_sel_low_n && pin[p].chip_sel_high |=> !pd_reg[p])
            else $error("selected cycle left port powered down");

         // capture and counter
         a_cap_inputs: assert property (@(posedge REF_CLK) disable iff (RST)
            port_edge[p] |=> cap_reg[p] == $past(pin[p]))
            else $error("port inputs not captured on port edge");

         a_cnt_hold: assert property (@(posedge REF_CLK) disable iff (RST)
            port_edge[p] && pin[p].burst_clear_n && pin[p].addr_strobe_n
            && pin[p].burst_incr_n |=> $stable(cnt_reg[p]))
            else $error("counter moved without increment");

         a_cnt_wrap: assert property (@(posedge REF_CLK) disable iff (RST)
            port_edge[p] && pin[p].burst_clear_n && pin[p].addr_strobe_n
            && !pin[p].burst_incr_n && cnt_reg[p] == '1 |=> cnt_reg[p] == `DPS_CNT_RST)
            else $error("counter did not wrap to zero");

         // array access
         a_desel_keep: assert property (@(posedge REF_CLK) disable iff (RST)
            acc_reg[p] && !sel_cap[p] && !wr_clash[p]
            |=> mem[$past(cnt_reg[p])] == $past(mem[cnt_reg[p]]))
            else $error("deselected cycle changed the array");

         a_lo_write: assert property (@(posedge REF_CLK) disable iff (RST)
            wr_go[p] && lane_cap[p][0] && !wr_clash[p]
            |=> mem[$past(cnt_reg[p])][`DPS_LO_LSB +: `DPS_LANE_W]
            == $past(cap_reg[p].wdata[`DPS_LO_LSB +: `DPS_LANE_W]))
            else $error("low lane not written");

         a_lo_keep: assert property (@(posedge REF_CLK) disable iff (RST)
            wr_go[p] && !lane_cap[p][0] && !wr_clash[p]
            |=> mem[$past(cnt_reg[p])][`DPS_LO_LSB +: `DPS_LANE_W]
            == $past(mem[cnt_reg[p]][`DPS_LO_LSB +: `DPS_LANE_W]))
            else $error("unselected low lane changed");

         a_up_write: assert property (@(posedge REF_CLK) disable iff (RST)
            wr_go[p] && lane_cap[p][1] && !wr_clash[p]
            |=> mem[$past(cnt_reg[p])][`DPS_HI_LSB +: `DPS_LANE_W]
            == $past(cap_reg[p].wdata[`DPS_HI_LSB +: `DPS_LANE_W]))
            else $error("upper lane not written");

         a_up_keep: assert property (@(posedge REF_CLK) disable iff (RST)
            wr_go[p] && !lane_cap[p][1] && !wr_clash[p]
            |=> mem[$past(cnt_reg[p])][`DPS_HI_LSB +: `DPS_LANE_W]
            == $past(mem[cnt_reg[p]][`DPS_HI_LSB +: `DPS_LANE_W]))
            else $error("unselected upper lane changed");

         a_read_word: assert property (@(posedge REF_CLK) disable iff (RST)
            rd_go[p] |=> rd_q_reg[p] == $past(mem[cnt_reg[p]]))
            else $error("read did not fetch addressed word");

         // output pins
         a_lane_gate: assert property (@(posedge REF_CLK) disable iff (RST)
            oe_reg[p] != `DPS_DATA_RST
            |-> (oe_reg[p] & ~$past(lane_mask[p])) == `DPS_DATA_RST)
            else $error("unselected lane driven");

         a_oe_off: assert property (@(posedge REF_CLK) disable iff (RST)
            $past(pin[p].out_en_n) |-> oe_reg[p] == `DPS_DATA_RST)
            else $error("pins still driven after output disable");

         a_pipe_stage: assert property (@(posedge REF_CLK) disable iff (RST)
            port_edge[p] && mode_cap[p] == DPS_PIPED
            |=> shown_lane_reg[p] == $past(pipe_lane_reg[p]))
            else $error("pipelined lanes not taken from output stage");

         c_burst: cover property (@(posedge REF_CLK) disable iff (RST)
            port_edge[p] && !pin[p].burst_incr_n && pin[p].addr_strobe_n);
         c_piped_read: cover property (@(posedge REF_CLK) disable iff (RST)
            rd_go[p] && mode_cap[p] == DPS_PIPED);
         c_flow_read: cover property (@(posedge REF_CLK) disable iff (RST)
            rd_go[p] && mode_cap[p] == DPS_FLOW);
      end
   endgenerate

   c_same_addr: cover property (@(posedge REF_CLK) disable iff (RST)
      acc_reg[0] && acc_reg[1] && cnt_reg[0] == cnt_reg[1]);

   c_wrap: cover property (@(posedge REF_CLK) disable iff (RST)
      port_edge[1] && !pin[1].burst_incr_n && cnt_reg[1] == '1);

endmodule : dps_top

// ### rtl/dps_defs.svh
// constants for the dual-port burst memory block
// assumes inclusion by rtl files of the same block only
`ifndef DPS_DEFS_SVH
`define DPS_DEFS_SVH

// array shape
`define DPS_AW 16
`define DPS_DW 18
`define DPS_DEPTH 65536
`define DPS_PORTS 2

// byte lanes
`define DPS_LANE_W 9
`define DPS_LO_LSB 0
`define DPS_HI_LSB 9

// reset values
`define DPS_CNT_RST 16'h0000
`define DPS_DATA_RST 18'h00000
`define DPS_LANE_OFF 2'h0

// flow_or_piped_sel level for pipelined output
`define DPS_PIPED_LVL 1'b1

`endif

// ### rtl/dps_pkg.sv
// types shared by the dual-port burst memory block
// assumes dps_defs.svh on the include path
`include "dps_defs.svh"

package dps_pkg;

   typedef logic [`DPS_AW-1:0] dps_addr_t;
   typedef logic [`DPS_DW-1:0] dps_data_t;
   typedef logic [1:0] dps_lane_t;

   typedef enum logic {
      DPS_FLOW,
      DPS_PIPED
   } dps_mode_e;

   // one port's pins as sampled on REF_CLK
   typedef struct packed {
      logic port_clk;
      dps_addr_t addr;
      logic addr_strobe_n;
      logic chip_sel_low_n;
      logic chip_sel_high;
      logic burst_incr_n;
      logic burst_clear_n;
      logic rd_wr_n;
      logic low_lane_sel_n;
      logic up_lane_sel_n;
      logic out_en_n;
      logic flow_or_piped_sel;
      dps_data_t wdata;
   } dps_port_in_s;

   // data pins split into value and per-bit enable
   typedef struct packed {
      dps_data_t rdata;
      dps_data_t rdata_oe;
      logic powered_down;
   } dps_port_out_s;

endpackage : dps_pkg

// ### bench/dps_host.sv
// host master model driving one memory port
// assumes REF_CLK from the bench; pins change on its falling edge
module dps_host (
   // clock
   input wire logic clk,
   // port pins
   output dps_pkg::dps_port_in_s pin
);
   timeunit 1ns;
   timeprecision 1ps;
   import dps_pkg::*;
   int cnt = 0;
   initial pin = {1'b0, {($bits(dps_port_in_s) - 1){1'b1}}};
   always @(posedge clk) cnt <= cnt + 1;
   // one port cycle, port clock low during setup, raised, then left high between cycles
   task automatic cyc(input dps_port_in_s p, output int e);
      p.port_clk = 1'b0;
      // released data lines show the inverse
      if (p.rd_wr_n) p.wdata = ~pin.wdata;
      @(negedge clk);
      pin <= p;
      repeat (3) @(negedge clk);
      pin.port_clk <= 1'b1;
      e = cnt + 1;
      // hold output enable until a flow-through result has been looked at
      repeat (4) @(negedge clk);
   endtask : cyc
endmodule : dps_host

// ### bench/dps_top_tb.sv
// self-checking bench for the dual-port burst memory
// assumes dps_host drives both ports; notes compared by a watcher
module dps_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dps_pkg::*;
   typedef struct {int due; dps_port_out_s exp; dps_port_out_s mask;} dps_note_s;
   localparam logic [3:0] LD_W = 4'h6, INC_W = 4'hc, LD_R = 4'h7, INC_R = 4'hd;
   localparam logic [4:0] ON = 5'h08, LO = 5'h0a, UP = 5'h0c, OE_OFF = 5'h09, DES = 5'h18;
   logic REF_CLK = 1'b0;
   logic RST = 1'b1;
   dps_port_in_s left_in, right_in;
   dps_port_out_s left_out, right_out;
   int failures = 0;
   int checks_done = 0;
   dps_note_s q[2][$];
   dps_note_s w;
   dps_addr_t mcnt[2];
   dps_data_t mem[int];
   logic [15:0] rnd = 16'h001e;
   dps_addr_t a;

   dps_top uut (.REF_CLK(REF_CLK), .RST(RST), .LEFT_IN(left_in), .LEFT_OUT(left_out),
      .RIGHT_IN(right_in), .RIGHT_OUT(right_out));
   dps_host host_l (.clk(REF_CLK), .pin(left_in));
   dps_host host_r (.clk(REF_CLK), .pin(right_in));

   initial begin
      forever #2.5 REF_CLK = ~REF_CLK;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   task automatic check(input string what, input dps_port_out_s seen, input dps_port_out_s exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic summarize();
      if (failures == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize

   function automatic dps_port_in_s mk(input logic [3:0] c, input logic [4:0] s, input logic m,
      input dps_addr_t ad, input dps_data_t d);
      return '{port_clk: 1'b0, addr: ad, addr_strobe_n: c[3], chip_sel_low_n: s[4],
         chip_sel_high: s[3], burst_incr_n: c[1], burst_clear_n: c[2], rd_wr_n: c[0],
         low_lane_sel_n: s[2], up_lane_sel_n: s[1], out_en_n: s[0], flow_or_piped_sel: m,
         wdata: d};
   endfunction : mk

   // predicts one port cycle, runs it, notes the expected pins
   task automatic run(input int s, input dps_port_in_s p, input logic chk);
      int e;
      dps_note_s n;
      logic sel;
      dps_data_t lm;
      dps_data_t oe;
      sel = !p.chip_sel_low_n && p.chip_sel_high;
      if (!p.burst_clear_n) mcnt[s] = '0;
      else if (!p.addr_strobe_n) mcnt[s] = p.addr;
      else if (!p.burst_incr_n) mcnt[s] = mcnt[s] + 16'h1;
      lm = {{9{!p.up_lane_sel_n}}, {9{!p.low_lane_sel_n}}};
      if (sel && !p.rd_wr_n) begin
         mem[mcnt[s]] = ((mem.exists(mcnt[s]) ? mem[mcnt[s]] : '0) & ~lm) | (p.wdata & lm);
      end
      oe = (sel && p.rd_wr_n && !p.out_en_n) ? lm : '0;
      n.exp = '{rdata: (oe != 0) ? mem[mcnt[s]] & oe : '0, rdata_oe: oe, powered_down: !sel};
      n.mask = '{rdata: oe, rdata_oe: '1, powered_down: !p.flow_or_piped_sel};
      if (s == 1) host_r.cyc(p, e);
      else host_l.cyc(p, e);
      n.due = e + (p.flow_or_piped_sel ? 9 : 4);
      if (chk) q[s].push_back(n);
   endtask : run

   always @(negedge REF_CLK) begin
      for (int s = 0; s < 2; s++) begin
         if (q[s].size() > 0 && q[s][0].due == host_l.cnt) begin
            w = q[s].pop_front();
            check(s ? "right pins" : "left pins", (s ? right_out : left_out) & w.mask,
               w.exp & w.mask);
         end
      end
   end

   initial begin
      #100000;
      failures++;
      summarize();
   end

   initial begin
      repeat (10) @(negedge REF_CLK);
      RST = 1'b0;
      rnd = lfsr(rnd);
      a = {2'b01, rnd[13:0]};
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         run(0, mk(i ? INC_W : LD_W, ON, 1'b0, i ? ~a : a, {rnd[1:0], rnd}), 1'b1);
      end
      for (int i = 0; i < 3; i++) begin
         fork
            run(0, mk(i ? INC_R : LD_R, ON, 1'b0, i ? ~a : a, '0), 1'b1);
            run(1, mk(i ? INC_R : LD_R, ON, 1'b0, i ? ~a : a, '0), 1'b1);
         join
      end
      run(1, mk(LD_W, ON, 1'b0, 16'hffff, 18'h2a5a5), 1'b1);
      run(1, mk(INC_W, ON, 1'b0, 16'h1234, 18'h15a5a), 1'b1);
      run(0, mk(4'h1, ON, 1'b0, 16'h5555, '0), 1'b1);
      run(1, mk(4'h5, ON, 1'b0, 16'hffff, '0), 1'b1);
      run(0, mk(LD_W, LO, 1'b0, a, 18'h3ffff), 1'b1);
      run(0, mk(LD_W, UP, 1'b0, a + 16'h1, '0), 1'b1);
      run(0, mk(LD_R, ON, 1'b0, a, '0), 1'b1);
      run(0, mk(LD_R, LO, 1'b0, a + 16'h1, '0), 1'b1);
      run(0, mk(LD_R, OE_OFF, 1'b0, a, '0), 1'b1);
      run(1, mk(LD_W, DES, 1'b0, a, '0), 1'b1);
      run(1, mk(LD_R, 5'h00, 1'b0, a, '0), 1'b1);
      run(1, mk(LD_R, ON, 1'b0, a, '0), 1'b1);
      for (int i = 0; i < 3; i++) begin
         run(0, mk(LD_R, ON, 1'b1, a + i[15:0], '0), i < 2);
      end
      repeat (20) @(negedge REF_CLK);
      check("pending notes", dps_port_out_s'(37'(q[0].size() + q[1].size())), '0);
      summarize();
   end
endmodule : dps_top_tb
